// file: src/sisp_pkg.sv
/*
 * Shared constants and types for the serial programming port.
 * Assumes a 40 MHz core clock; wait counts are derived from that rate.
 */
package sisp_pkg;
  // Core clock rate and self-timed wait figures (ms times ten)
  localparam int CLK_KHZ = 40000;
  localparam int FLASH_WAIT_MS10 = 45;
  localparam int EE_WAIT_MS10 = 36;
  localparam int ERASE_WAIT_MS10 = 90;
  localparam int FLASH_PAGE_WAIT_CYC = FLASH_WAIT_MS10 * CLK_KHZ / 10;
  localparam int EEPROM_WRITE_WAIT_CYC = EE_WAIT_MS10 * CLK_KHZ / 10;
  localparam int CHIP_ERASE_WAIT_CYC = ERASE_WAIT_MS10 * CLK_KHZ / 10;
  localparam int CNT_W = 20;
  // Instruction codes, first byte
  localparam logic [7:0] CMD_WIDE = 8'hAC;
  localparam logic [7:0] CMD_POLL = 8'hF0;
  localparam logic [7:0] CMD_LD_LO = 8'h40;
  localparam logic [7:0] CMD_LD_HI = 8'h48;
  localparam logic [7:0] CMD_LD_EE = 8'hC1;
  localparam logic [7:0] CMD_RD_LO = 8'h20;
  localparam logic [7:0] CMD_RD_HI = 8'h28;
  localparam logic [7:0] CMD_RD_EE = 8'hA0;
  localparam logic [7:0] CMD_RD_LK = 8'h58;
  localparam logic [7:0] CMD_RD_FS = 8'h50;
  localparam logic [7:0] CMD_RD_SIG = 8'h30;
  localparam logic [7:0] CMD_RD_CAL = 8'h38;
  localparam logic [7:0] CMD_WR_PAGE = 8'h4C;
  localparam logic [7:0] CMD_WR_EE = 8'hC0;
  localparam logic [7:0] CMD_WR_EEPG = 8'hC2;
  // Second byte selectors
  localparam logic [7:0] SEL_ENABLE = 8'h53;
  localparam logic [7:0] SEL_ERASE = 8'h80;
  localparam logic [7:0] SEL_LOCK = 8'hE0;
  localparam logic [7:0] SEL_FLO = 8'hA0;
  localparam logic [7:0] SEL_FHI = 8'hA8;
  localparam logic [7:0] SEL_FEXT = 8'hA4;
  localparam logic [7:0] SEL_RD_ALT = 8'h08;
  // Bit positions within a 32-bit instruction
  localparam logic [5:0] BIT_ECHO = 6'h10;
  localparam logic [5:0] BIT_HDR = 6'h17;
  localparam logic [5:0] BIT_RESP = 6'h18;
  localparam logic [5:0] BIT_LAST = 6'h1F;
  localparam int PG_WORD_AW = 6;
  localparam int EE_PG_AW = 2;
  // Reset and erased values; fuse and lock 1 means unprogrammed
  localparam logic [7:0] ERASED_B = 8'hFF;
  localparam logic [15:0] ERASED_W = 16'hFFFF;
  localparam logic [7:0] FUSE_LO_RST = 8'hFF;
  localparam logic [7:0] FUSE_HI_RST = 8'hFF;
  localparam logic [7:0] FUSE_EXT_RST = 8'hFF;
  localparam logic [7:0] LOCK_RST = 8'hFF;
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [7:0] b4;
  } sisp_frame_t;
  typedef enum {JOB_NONE, JOB_FPAGE, JOB_EEBYTE, JOB_EEPAGE, JOB_ERASE,
                JOB_FUSE} sisp_job_t;
endpackage

// file: src/sisp_port.sv
/*
 * Serial programming port: shifts 32-bit instructions in on the
 * programmer's clock, executes them against flash, EEPROM, fuse and
 * lock storage in the core domain, and shifts answers back out.
 * Assumes the programmer holds the reset pin low for the session and
 * keeps each serial clock phase at least four core cycles long.
 */
`timescale 1ns/100ps
module sisp_port #(
  parameter int FLASH_AW = 12,
  parameter int EE_AW = 6,
  parameter int FLASH_PAGE_WAIT = sisp_pkg::FLASH_PAGE_WAIT_CYC,
  parameter int EEPROM_WRITE_WAIT = sisp_pkg::EEPROM_WRITE_WAIT_CYC,
  parameter int CHIP_ERASE_WAIT = sisp_pkg::CHIP_ERASE_WAIT_CYC,
  parameter logic [7:0] SIG0 = 8'h11, // Arbitrary identity value
  parameter logic [7:0] SIG1 = 8'h22, // Arbitrary identity value
  parameter logic [7:0] SIG2 = 8'h33, // Arbitrary identity value
  parameter logic [7:0] CAL_BYTE = 8'h80
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic sck_i,
  input wire logic prog_rst_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic prog_mode_o,
  output logic busy_o
);
  import sisp_pkg::*;

  localparam logic [CNT_W-1:0] FL_N = CNT_W'(2 ** FLASH_AW);
  localparam logic [CNT_W-1:0] EE_N = CNT_W'(2 ** EE_AW);
  localparam logic [CNT_W-1:0] PG_N = CNT_W'(2 ** PG_WORD_AW);
  localparam logic [CNT_W-1:0] EP_N = CNT_W'(2 ** EE_PG_AW);

  function automatic logic [FLASH_AW-1:0] fl_adr(logic [7:0] hi,
                                                 logic [7:0] lo);
    logic [15:0] w;
    w = {hi, lo};
    return w[FLASH_AW-1:0];
  endfunction

  function automatic logic [EE_AW-1:0] ee_adr(logic [7:0] hi,
                                              logic [7:0] lo);
    logic [15:0] w;
    w = {hi, lo};
    return w[EE_AW-1:0];
  endfunction

  // Link-side state; all but link_rst_q and resp_q clocked by the programmer's serial clock
  logic link_rst_q, link_rst_d;
  logic [5:0] bit_q, bit_d;
  logic [31:0] sh_q, sh_d;
  logic [7:0] tx_q, tx_d;
  logic hdr_tg_q, hdr_tg_d, frm_tg_q, frm_tg_d;
  sisp_frame_t hdr_q, hdr_d, frm_q, frm_d;
  logic [7:0] resp_q, resp_d;

  // Shift in on rise, wrap after exactly 32 bits
  always_comb begin
    bit_d = (bit_q == BIT_LAST) ? 6'h00 : bit_q + 6'h01;
    sh_d = {sh_q[30:0], mosi_i};
    hdr_d = hdr_q;
    hdr_tg_d = hdr_tg_q;
    frm_d = frm_q;
    frm_tg_d = frm_tg_q;
    if (bit_q == BIT_HDR) begin
      hdr_d = {sh_q[22:0], mosi_i, 8'h00};
      hdr_tg_d = ~hdr_tg_q;
    end
    if (bit_q == BIT_LAST) begin
      frm_d = {sh_q[30:0], mosi_i};
      frm_tg_d = ~frm_tg_q;
    end
  end

  // reset pulse realigns the bit counter
  always_ff @(posedge sck_i or posedge link_rst_q) begin
    if (link_rst_q) begin
      bit_q <= 6'h00;
      sh_q <= 32'h0000_0000;
      hdr_q <= '0;
      hdr_tg_q <= 1'b0;
      frm_q <= '0;
      frm_tg_q <= 1'b0;
    end else begin
      bit_q <= bit_d;
      sh_q <= sh_d;
      hdr_q <= hdr_d;
      hdr_tg_q <= hdr_tg_d;
      frm_q <= frm_d;
      frm_tg_q <= frm_tg_d;
    end
  end

  // Output shifter; answer byte is read quasi-static
  always_comb begin
    tx_d = {tx_q[6:0], 1'b0};
    if (bit_q == BIT_ECHO)
      tx_d = sh_q[7:0];
    // answer settles within one clock phase
    else if (bit_q == BIT_RESP)
      tx_d = resp_q;
  end

  always_ff @(negedge sck_i or posedge link_rst_q) begin
    if (link_rst_q)
      tx_q <= 8'h00;
    else
      tx_q <= tx_d;
  end

  assign miso_o = tx_q[7];

  // Core-side state
  logic rst_s1_q, rst_s2_q, mode_q, mode_d, en_q, en_d;
  logic hs1_q, hs2_q, hs3_q, fs1_q, fs2_q, fs3_q;
  sisp_job_t job_q, job_d;
  logic [CNT_W-1:0] cnt_q, cnt_d, lim_q, lim_d;
  logic [15:0] adr_q, adr_d;
  logic [7:0] dat_q, dat_d, sel_q, sel_d;
  logic [7:0] flo_q, flo_d, fhi_q, fhi_d, fext_q, fext_d, lock_q, lock_d;
  logic [3:0] eld_q, eld_d;
  logic [3:0][7:0] ebuf_q, ebuf_d;
  logic hdr_ev, frm_ev;
  logic [15:0] fl_mem [2**FLASH_AW];
  logic [7:0] ee_mem [2**EE_AW];
  logic [7:0] pb_lo [2**PG_WORD_AW];
  logic [7:0] pb_hi [2**PG_WORD_AW];
  logic fl_we, ee_we, pl_we, ph_we;
  logic [FLASH_AW-1:0] fl_wa;
  logic [15:0] fl_wd;
  logic [EE_AW-1:0] ee_wa;
  logic [7:0] ee_wd;
  logic [PG_WORD_AW-1:0] pb_wa;
  logic [7:0] pb_wd;

  assign hdr_ev = hs2_q ^ hs3_q;
  assign frm_ev = fs2_q ^ fs3_q;

  // Answer byte for byte four, chosen once bytes one to three are in
  always_comb begin
    resp_d = resp_q;
    if (hdr_ev) begin
      resp_d = 8'h00;
      case (hdr_q.op)
        CMD_POLL: resp_d = {7'h00, job_q != JOB_NONE};
        CMD_RD_LO: resp_d = fl_mem[fl_adr(hdr_q.b2, hdr_q.b3)][7:0];
        CMD_RD_HI: resp_d = fl_mem[fl_adr(hdr_q.b2, hdr_q.b3)][15:8];
        CMD_RD_EE: resp_d = ee_mem[ee_adr(hdr_q.b2, hdr_q.b3)];
        CMD_RD_LK: resp_d = (hdr_q.b2 == SEL_RD_ALT) ? fhi_q : lock_q;
        CMD_RD_FS: resp_d = (hdr_q.b2 == SEL_RD_ALT) ? fext_q : flo_q;
        CMD_RD_SIG: begin
          case (hdr_q.b3[1:0])
            2'h1: resp_d = SIG1;
            2'h2: resp_d = SIG2;
            default: resp_d = SIG0;
          endcase
        end
        CMD_RD_CAL: resp_d = CAL_BYTE;
        default: resp_d = 8'h00;
      endcase
    end
  end

  // Instruction execution and self-timed jobs
  always_comb begin
    mode_d = ~rst_s2_q;
    link_rst_d = ~mode_q;
    en_d = en_q;
    job_d = job_q;
    cnt_d = cnt_q;
    lim_d = lim_q;
    adr_d = adr_q;
    dat_d = dat_q;
    sel_d = sel_q;
    flo_d = flo_q;
    fhi_d = fhi_q;
    fext_d = fext_q;
    lock_d = lock_q;
    eld_d = eld_q;
    ebuf_d = ebuf_q;
    fl_we = 1'b0;
    fl_wa = '0;
    fl_wd = 16'h0000;
    ee_we = 1'b0;
    ee_wa = '0;
    ee_wd = 8'h00;
    pl_we = 1'b0;
    ph_we = 1'b0;
    pb_wa = frm_q.b3[PG_WORD_AW-1:0];
    pb_wd = frm_q.b4;
    if (job_q != JOB_NONE) begin
      cnt_d = (cnt_q == lim_q) ? '0 : cnt_q + CNT_W'(1);
      if (cnt_q == lim_q)
        job_d = JOB_NONE;
      case (job_q)
        // commit one buffered word per cycle
        JOB_FPAGE: begin
          fl_we = cnt_q < PG_N;
          fl_wa = fl_adr(adr_q[15:8], adr_q[7:0]) |
                  FLASH_AW'(cnt_q[PG_WORD_AW-1:0]);
          fl_wd = {pb_hi[cnt_q[PG_WORD_AW-1:0]],
                   pb_lo[cnt_q[PG_WORD_AW-1:0]]};
        end
        JOB_EEBYTE: begin
          ee_we = cnt_q < CNT_W'(2);
          ee_wa = ee_adr(adr_q[15:8], adr_q[7:0]);
          ee_wd = (cnt_q == '0) ? ERASED_B : dat_q;
        end
        JOB_EEPAGE: begin
          ee_we = (cnt_q < EP_N) && eld_q[cnt_q[EE_PG_AW-1:0]];
          ee_wa = ee_adr(adr_q[15:8], adr_q[7:0]) |
                  EE_AW'(cnt_q[EE_PG_AW-1:0]);
          ee_wd = ebuf_q[cnt_q[EE_PG_AW-1:0]];
          if (cnt_q == lim_q)
            eld_d = 4'h0;
        end
        // walk both arrays to the erased value
        JOB_ERASE: begin
          fl_we = cnt_q < FL_N;
          fl_wa = cnt_q[FLASH_AW-1:0];
          fl_wd = ERASED_W;
          ee_we = cnt_q < EE_N;
          ee_wa = cnt_q[EE_AW-1:0];
          ee_wd = ERASED_B;
          lock_d = ERASED_B;
        end
        // store the selected fuse or lock byte
        JOB_FUSE: begin
          if (cnt_q == '0) begin
            case (sel_q)
              SEL_LOCK: lock_d = dat_q;
              SEL_FLO: flo_d = dat_q;
              SEL_FHI: fhi_d = dat_q;
              SEL_FEXT: fext_d = dat_q;
              default: lock_d = lock_q;
            endcase
          end
        end
        default: job_d = JOB_NONE;
      endcase
    end
    if (frm_ev && mode_q) begin
      if (frm_q.op == CMD_WIDE && frm_q.b2 == SEL_ENABLE)
        en_d = 1'b1;
      else if (en_q && job_q == JOB_NONE) begin
        adr_d = {frm_q.b2, frm_q.b3};
        dat_d = frm_q.b4;
        sel_d = frm_q.b2;
        cnt_d = '0;
        case (frm_q.op)
          // low byte $40, high byte $48
          CMD_LD_LO: pl_we = 1'b1;
          CMD_LD_HI: ph_we = 1'b1;
          CMD_LD_EE: begin
            ebuf_d[frm_q.b3[EE_PG_AW-1:0]] = frm_q.b4;
            eld_d[frm_q.b3[EE_PG_AW-1:0]] = 1'b1;
          end
          CMD_WR_PAGE: begin
            job_d = JOB_FPAGE;
            lim_d = CNT_W'(FLASH_PAGE_WAIT - 1);
            adr_d = {frm_q.b2, frm_q.b3 & 8'hC0};
          end
          CMD_WR_EE: begin
            job_d = JOB_EEBYTE;
            lim_d = CNT_W'(EEPROM_WRITE_WAIT - 1);
          end
          CMD_WR_EEPG: begin
            job_d = JOB_EEPAGE;
            lim_d = CNT_W'(EEPROM_WRITE_WAIT - 1);
            adr_d = {frm_q.b2, frm_q.b3 & 8'hFC};
          end
          CMD_WIDE: begin
            job_d = (frm_q.b2 == SEL_ERASE) ? JOB_ERASE : JOB_FUSE;
            lim_d = (frm_q.b2 == SEL_ERASE) ?
                    CNT_W'(CHIP_ERASE_WAIT - 1) :
                    CNT_W'(EEPROM_WRITE_WAIT - 1);
          end
          default: job_d = JOB_NONE;
        endcase
      end
    end
    if (!mode_q) begin
      en_d = 1'b0;
      eld_d = 4'h0;
    end
  end

  // Core registers; pin and toggles pass two flops first
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= 1'b1;
      {hs1_q, hs2_q, hs3_q, fs1_q, fs2_q, fs3_q} <= 6'h00;
      mode_q <= 1'b0;
      link_rst_q <= 1'b1;
      en_q <= 1'b0;
      job_q <= JOB_NONE;
      cnt_q <= '0;
      lim_q <= '0;
      adr_q <= 16'h0000;
      dat_q <= 8'h00;
      sel_q <= 8'h00;
      resp_q <= 8'h00;
      flo_q <= FUSE_LO_RST;
      fhi_q <= FUSE_HI_RST;
      fext_q <= FUSE_EXT_RST;
      lock_q <= LOCK_RST;
      eld_q <= 4'h0;
      ebuf_q <= '0;
    end else begin
      rst_s1_q <= prog_rst_n_i;
      rst_s2_q <= rst_s1_q;
      {hs1_q, hs2_q, hs3_q} <= {hdr_tg_q, hs1_q, hs2_q};
      {fs1_q, fs2_q, fs3_q} <= {frm_tg_q, fs1_q, fs2_q};
      mode_q <= mode_d;
      link_rst_q <= link_rst_d;
      en_q <= en_d;
      job_q <= job_d;
      cnt_q <= cnt_d;
      lim_q <= lim_d;
      adr_q <= adr_d;
      dat_q <= dat_d;
      sel_q <= sel_d;
      resp_q <= resp_d;
      flo_q <= flo_d;
      fhi_q <= fhi_d;
      fext_q <= fext_d;
      lock_q <= lock_d;
      eld_q <= eld_d;
      ebuf_q <= ebuf_d;
    end
  end

  // Storage arrays keep no reset; contents survive a session
  always_ff @(posedge clk_i) begin
    if (fl_we)
      fl_mem[fl_wa] <= fl_wd;
    if (ee_we)
      ee_mem[ee_wa] <= ee_wd;
    if (pl_we)
      pb_lo[pb_wa] <= pb_wd;
    if (ph_we)
      pb_hi[pb_wa] <= pb_wd;
  end

  assign prog_mode_o = mode_q;
  assign busy_o = job_q != JOB_NONE;

  sequence s_flash_cmd;
    frm_ev && mode_q && en_q && job_q == JOB_NONE &&
      frm_q.op == CMD_WR_PAGE;
  endsequence
  sequence s_job_run;
    busy_o && cnt_q == '0;
  endsequence

  a_poll_busy_bit: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    hdr_ev && hdr_q.op == CMD_POLL |=> resp_q == {7'h00, $past(busy_o)})
    else $error("poll answer does not match busy state");
  a_reject_unenabled: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    frm_ev && !en_q && !busy_o && frm_q.op != CMD_WIDE |=> !busy_o)
    else $error("write started before enable");
  a_page_write_start: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    s_flash_cmd |=> s_job_run ##1 busy_o && cnt_q == CNT_W'(1))
    else $error("page write did not start");
  a_busy_holds: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    busy_o && cnt_q != lim_q |=> busy_o)
    else $error("job ended before its wait count");
  a_ee_erase_first: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    job_q == JOB_EEBYTE && cnt_q == '0 |-> ee_we && ee_wd == ERASED_B
      ##1 ee_we && ee_wd == dat_q)
    else $error("EEPROM byte not erased then written");
  a_page_load_low: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    frm_ev && mode_q && en_q && !busy_o && frm_q.op == CMD_LD_LO
      |=> pb_lo[$past(pb_wa)] == $past(frm_q.b4))
    else $error("page buffer low byte not loaded");
  a_flash_read_lo: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    hdr_ev && hdr_q.op == CMD_RD_LO && !fl_we
      |=> resp_q == fl_mem[fl_adr(hdr_q.b2, hdr_q.b3)][7:0])
    else $error("flash low byte read wrong");
  a_fuse_store: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    job_q == JOB_FUSE && cnt_q == '0 && sel_q == SEL_FLO
      |=> flo_q == $past(dat_q))
    else $error("fuse low byte not stored");
  a_leave_mode: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    rst_s2_q |=> !prog_mode_o ##1 !en_q && link_rst_q)
    else $error("programming mode not left on reset release");
  // The echoed bit trails the received stream by eight clocks, so it
  // always sits at shifter position seven at a rise
  a_echo_second: assert property (
    @(posedge sck_i) disable iff (link_rst_q)
    bit_q == BIT_ECHO + 6'h01 |-> miso_o == sh_q[7])
    else $error("second byte not echoed");
endmodule

// file: tb/sisp_prog_model.sv
/*
 * Behavioural in-system programmer: drives the reset pin, serial
 * clock and data-in, and collects data-out during bytes three and four.
 * Assumes the port samples on clock rise and shifts out on clock fall.
 */
`timescale 1ns/100ps
module sisp_prog_model #(
  parameter int HALF_NS = 120
) (
  output logic sck_o,
  output logic mosi_o,
  output logic prog_rst_n_o,
  input wire logic miso_i
);
  import sisp_pkg::*;
  // Pin and clock low at power-up
  initial begin
    sck_o = 1'b0;
    mosi_o = 1'b0;
    prog_rst_n_o = 1'b0;
  end
  // Drive the reset pin; low keeps the session open
  task automatic set_pin(input logic v);
    prog_rst_n_o <= v;
  endtask
  task automatic xfer(input sisp_frame_t f, output logic [7:0] echo,
                      output logic [7:0] ans);
    logic [31:0] w;
    logic [15:0] got;
    w = f;
    got = 16'h0000;
    for (int i = 31; i >= 0; i--) begin
      mosi_o <= w[i];
      #HALF_NS;
      got = {got[14:0], miso_i}; // Settled since the last fall
      sck_o <= 1'b1;
      #HALF_NS;
      sck_o <= 1'b0;
    end
    #HALF_NS;
    echo = got[15:8];
    ans = got[7:0];
  endtask
  // Stray clocks that knock the link out of byte alignment
  task automatic slip(input int n);
    for (int i = 0; i < n; i++) begin
      #HALF_NS;
      sck_o <= 1'b1;
      #HALF_NS;
      sck_o <= 1'b0;
    end
  endtask
endmodule

// file: tb/serial_isp_programming_port_tb.sv
/*
 * Self-checking bench for the serial programming port.
 * Assumes the programmer model above and shortened self-timed waits.
 */
`timescale 1ns/100ps
module serial_isp_programming_port_tb;
  import sisp_pkg::*;
  localparam int FP = 128;
  localparam int EW = 16;
  localparam int CE = 4200;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic sck, mosi, prog_rst_n, miso, prog_mode, busy;
  logic [7:0] rx_echo, rx_ans;
  int fail_count = 0;
  int compares = 0;
  logic [7:0] fsel [4] = '{8'hE0, 8'hA0, 8'hA8, 8'hA4};
  logic [7:0] fop [4] = '{8'h58, 8'h50, 8'h58, 8'h50};
  logic [7:0] fb2 [4] = '{8'h00, 8'h00, 8'h08, 8'h08};
  logic [7:0] fdat [4] = '{8'h3C, 8'h62, 8'hDF, 8'hFE};
  // Core clock, 25 ns
  always #12.5 clk_i = ~clk_i;
  sisp_port #(
    .FLASH_PAGE_WAIT(FP),
    .EEPROM_WRITE_WAIT(EW),
    .CHIP_ERASE_WAIT(CE)
  ) i_sisp_port (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .sck_i(sck),
    .prog_rst_n_i(prog_rst_n),
    .mosi_i(mosi),
    .miso_o(miso),
    .prog_mode_o(prog_mode),
    .busy_o(busy)
  );
  sisp_prog_model i_sisp_prog_model (
    .sck_o(sck),
    .mosi_o(mosi),
    .prog_rst_n_o(prog_rst_n),
    .miso_i(miso)
  );
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string msg);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h", $time, msg, got);
    end
  endtask
  task automatic cmd(input logic [7:0] a, input logic [7:0] b,
                     input logic [7:0] c, input logic [7:0] d);
    sisp_frame_t f;
    f = {a, b, c, d};
    @(posedge clk_i);
    i_sisp_prog_model.xfer(f, rx_echo, rx_ans);
  endtask
  // Poll instead of a fixed wait
  task automatic wait_ready();
    for (int i = 0; i < 40; i++) begin
      cmd(CMD_POLL, 8'h00, 8'h00, 8'h00);
      if (rx_ans[0] === 1'b0) return;
    end
    fail_count++;
    $display("unexpected at %0t: busy never cleared", $time);
    wrap_up();
  endtask
  // Enable sent before any other instruction
  task automatic t_enable();
    cmd(CMD_WIDE, SEL_ENABLE, 8'h00, 8'h00);
    chk(rx_echo, 8'h53, "enable echo");
    chk({7'h00, prog_mode}, 8'h01, "mode flag");
    $display("test enable done");
  endtask
  task automatic t_erase();
    cmd(CMD_WIDE, SEL_ERASE, 8'h00, 8'h00);
    cmd(CMD_POLL, 8'h00, 8'h00, 8'h00);
    chk(rx_ans & 8'h01, 8'h01, "poll while erasing");
    wait_ready();
    cmd(CMD_RD_LO, 8'h01, 8'h23, 8'h00);
    chk(rx_ans, ERASED_B, "flash low erased");
    cmd(CMD_RD_HI, 8'h0F, 8'hFF, 8'h00);
    chk(rx_ans, ERASED_B, "flash high erased");
    cmd(CMD_RD_EE, 8'h00, 8'h3F, 8'h00);
    chk(rx_ans, ERASED_B, "eeprom erased");
    $display("test erase done");
  endtask
  task automatic t_ids();
    cmd(CMD_RD_SIG, 8'h00, 8'h00, 8'h00);
    chk(rx_ans, 8'h11, "signature 0");
    cmd(CMD_RD_SIG, 8'h00, 8'h01, 8'h00);
    chk(rx_ans, 8'h22, "signature 1");
    cmd(CMD_RD_SIG, 8'h00, 8'h02, 8'h00);
    chk(rx_ans, 8'h33, "signature 2");
    cmd(CMD_RD_CAL, 8'h00, 8'h00, 8'h00);
    chk(rx_ans, 8'h80, "calibration");
    $display("test ids done");
  endtask
  task automatic t_fuses();
    for (int i = 0; i < 4; i++) begin
      cmd(fop[i], fb2[i], 8'h00, 8'h00);
      chk(rx_ans, 8'hFF, "fuse unprogrammed");
    end
    for (int i = 0; i < 4; i++) begin
      cmd(CMD_WIDE, fsel[i], 8'h00, fdat[i]);
      wait_ready();
    end
    for (int i = 0; i < 4; i++) begin
      cmd(fop[i], fb2[i], 8'h00, 8'h00);
      chk(rx_ans, fdat[i], "fuse readback");
    end
    $display("test fuses done");
  endtask
  task automatic t_flash_page();
    int cnt;
    cnt = 0;
    cmd(CMD_LD_LO, 8'h00, 8'h03, 8'hA5);
    cmd(CMD_LD_HI, 8'h00, 8'h03, 8'h5A);
    cmd(CMD_LD_LO, 8'h00, 8'h3F, 8'h11);
    cmd(CMD_LD_HI, 8'h00, 8'h3F, 8'h22);
    cmd(CMD_WR_PAGE, 8'h00, 8'h40, 8'h00);
    for (int i = 0; i < FP + 60; i++) begin
      // Sample mid-cycle, away from the edge that moves busy
      @(negedge clk_i);
      if (busy === 1'b1) cnt++;
      else if (cnt > 0) break;
    end
    chk(8'(cnt >= FP - 8 && cnt <= FP), 8'h01, "page busy span");
    cmd(CMD_RD_LO, 8'h00, 8'h43, 8'h00);
    chk(rx_ans, 8'hA5, "flash low");
    cmd(CMD_RD_HI, 8'h00, 8'h43, 8'h00);
    chk(rx_ans, 8'h5A, "flash high");
    cmd(CMD_RD_LO, 8'h00, 8'h7F, 8'h00);
    chk(rx_ans, 8'h11, "flash low top word");
    cmd(CMD_RD_HI, 8'h00, 8'h7F, 8'h00);
    chk(rx_ans, 8'h22, "flash high top word");
    $display("test flash page done");
  endtask
  task automatic t_eeprom();
    cmd(CMD_WR_EE, 8'h00, 8'h08, 8'h3C);
    wait_ready();
    cmd(CMD_RD_EE, 8'h00, 8'h08, 8'h00);
    chk(rx_ans, 8'h3C, "eeprom byte");
    cmd(CMD_LD_EE, 8'h00, 8'h01, 8'h77);
    cmd(CMD_WR_EEPG, 8'h00, 8'h08, 8'h00);
    wait_ready();
    cmd(CMD_RD_EE, 8'h00, 8'h09, 8'h00);
    chk(rx_ans, 8'h77, "eeprom page loaded");
    cmd(CMD_RD_EE, 8'h00, 8'h08, 8'h00);
    chk(rx_ans, 8'h3C, "eeprom page kept");
    cmd(CMD_RD_EE, 8'h00, 8'h0A, 8'h00);
    chk(rx_ans, 8'hFF, "eeprom page untouched");
    $display("test eeprom done");
  endtask
  task automatic t_leave();
    i_sisp_prog_model.set_pin(1'b1);
    repeat (8) @(posedge clk_i);
    chk({7'h00, prog_mode}, 8'h00, "mode left");
    i_sisp_prog_model.set_pin(1'b0);
    repeat (10) @(posedge clk_i);
    cmd(CMD_WR_EE, 8'h00, 8'h08, 8'h55);
    repeat (8) @(posedge clk_i);
    chk({7'h00, busy}, 8'h00, "write refused busy");
    cmd(CMD_RD_EE, 8'h00, 8'h08, 8'h00);
    chk(rx_ans, 8'h3C, "write refused data");
    $display("test leave done");
  endtask
  // Missing echo: pulse reset, enable again
  task automatic t_resync();
    i_sisp_prog_model.slip(1);
    cmd(CMD_WIDE, SEL_ENABLE, 8'h00, 8'h00);
    compares++;
    // An unknown echo counts as a failure too
    if (rx_echo === 8'h53 || $isunknown(rx_echo)) begin
      fail_count++;
      $display("unexpected at %0t: echo while misaligned", $time);
    end
    i_sisp_prog_model.set_pin(1'b1);
    repeat (4) @(posedge clk_i);
    i_sisp_prog_model.set_pin(1'b0);
    repeat (10) @(posedge clk_i);
    cmd(CMD_WIDE, SEL_ENABLE, 8'h00, 8'h00);
    chk(rx_echo, 8'h53, "echo after resync");
    $display("test resync done");
  endtask
  // Main sequence; the settle wait is short since the port only needs
  // a few core cycles after the pin falls
  initial begin
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    t_enable();
    t_erase();
    t_ids();
    t_fuses();
    t_flash_page();
    t_eeprom();
    t_leave();
    t_resync();
    wrap_up();
  end
endmodule
